// [hdl/radio_cmd_pkg.sv]
// constants for the radio command decoder: register map, command ids, status codes
// assumes a 32-bit axi4-lite slave with byte addresses and one word per register
package radio_cmd_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD          = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_QUERY_RESULT = 8'h08;
  localparam logic [7:0] ADDR_CHAN_WHITEN  = 8'h0C;
  localparam logic [7:0] ADDR_PARAM_PTR    = 8'h10;
  localparam logic [7:0] ADDR_RESULT_PTR   = 8'h14;
  localparam logic [7:0] ADDR_PAYLOAD_DESC = 8'h18;
  localparam logic [7:0] ADDR_NEW_DATA_PTR = 8'h1C;
  localparam logic [7:0] ADDR_TARGET_PTR   = 8'h20;
  localparam logic [7:0] ADDR_RX_QUEUE     = 8'h24;
  localparam logic [7:0] ADDR_TX_QUEUE     = 8'h28;
  localparam logic [7:0] ADDR_QUEUE_CFG    = 8'h2C;
  localparam logic [7:0] ADDR_ACCESS_WORD  = 8'h30;
  localparam logic [7:0] ADDR_SEED_TRIG    = 8'h34;
  localparam logic [7:0] ADDR_TIMEOUT_TIME = 8'h38;
  localparam logic [7:0] ADDR_CLOSE_TRIG   = 8'h3C;
  localparam logic [7:0] ADDR_CLOSE_TIME   = 8'h40;
  localparam logic [7:0] ADDR_RADIO_STATE  = 8'h44;
  // command word: identifier in the upper half
  localparam int CMD_ID_LSB = 16;
  // command identifiers
  localparam logic [15:0] ID_FG_STOP        = 16'h2C01;
  localparam logic [15:0] ID_CLEAR_QUERY    = 16'h2C02;
  localparam logic [15:0] ID_PAYLOAD_UPDATE = 16'h1001;
  localparam logic [15:0] ID_LE_OP_FIRST    = 16'h1801;
  localparam logic [15:0] ID_LE_OP_LAST     = 16'h180A;
  // command status word codes
  localparam logic [7:0] STA_IDLE          = 8'h00;
  localparam logic [7:0] STA_DONE          = 8'h01;
  localparam logic [7:0] STA_PARAM_ERROR   = 8'h82;
  localparam logic [7:0] STA_UNKNOWN_CMD   = 8'h83;
  localparam logic [7:0] STA_WRONG_CONTEXT = 8'h85;
  // signal strength marker for no valid reading
  localparam logic [7:0] STRENGTH_INVALID = 8'h80;
  // channel byte ranges
  localparam logic [7:0] CHAN_PROTO_LAST   = 8'd39;
  localparam logic [7:0] CHAN_CUSTOM_FIRST = 8'd60;
  localparam logic [7:0] CHAN_CUSTOM_LAST  = 8'd207;
  localparam logic [7:0] CHAN_KEEP         = 8'd255;
  localparam logic [11:0] CUSTOM_BASE_MHZ  = 12'd2300;
  // whitening byte fields
  localparam int WHITEN_OVERRIDE_BIT = 7;
  // common header length; channel byte sits right after it
  localparam int HEADER_BYTES       = 14;
  localparam int CHAN_BYTE_INDEX    = HEADER_BYTES;
  localparam int WHITEN_BYTE_INDEX  = HEADER_BYTES + 1;
  // payload kinds
  localparam logic [7:0] KIND_ADVERT_DATA = 8'd0;
  localparam logic [7:0] KIND_SCAN_RESP   = 8'd1;
  // queue config word byte positions
  localparam int CFG_SEQ_LSB  = 8;
  localparam int CFG_NACK_LSB = 16;
  localparam int CFG_PKT_LSB  = 24;
  // query result field positions
  localparam int RES_PEAK_LSB   = 8;
  localparam int RES_COMBINED   = 16;
  localparam int RES_ENERGY     = 17;
  localparam int RES_CORRELATOR = 18;
  localparam int RES_SYNCWORD   = 19;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : radio_cmd_pkg

// [hdl/channel_byte_decode.sv]
// channel and whitening byte decode for the common radio operation structure
// assumes bytes come straight from the channel register; purely combinational
`timescale 1ns/100ps
module channel_byte_decode
  import radio_cmd_pkg::*;
(
  input  wire logic [7:0]  channel_i,
  input  wire logic [7:0]  whitening_i,
  output logic             legal_o,
  output logic             keep_freq_o,
  output logic             custom_o,
  output logic [11:0]      freq_mhz_o,
  output logic             whiten_en_o,
  output logic             whiten_default_o,
  output logic [6:0]       whiten_seed_o
);
  logic proto;
  logic override;

  always_comb begin
    proto       = (channel_i <= CHAN_PROTO_LAST);
    custom_o    = (channel_i >= CHAN_CUSTOM_FIRST) && (channel_i <= CHAN_CUSTOM_LAST);
    keep_freq_o = (channel_i == CHAN_KEEP);
    legal_o     = proto || custom_o || keep_freq_o;
    freq_mhz_o  = CUSTOM_BASE_MHZ + {4'h0, channel_i};
    override    = whitening_i[WHITEN_OVERRIDE_BIT];
    whiten_seed_o = whitening_i[6:0];
    if (override || custom_o) begin
      whiten_default_o = 1'b0;
      whiten_en_o      = (whitening_i[6:0] != 7'h00);
    end else begin
      whiten_default_o = 1'b1;
      whiten_en_o      = 1'b1;
    end
  end
endmodule : channel_byte_decode

// [hdl/strength_tracker.sv]
// peak signal strength since the background operation began
// assumes strength samples and activity level are on the core clock
`timescale 1ns/100ps
module strength_tracker
  import radio_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        bg_active_i,
  input  wire logic [7:0]  strength_i,
  input  wire logic        strength_valid_i,
  output logic [7:0]       peak_o,
  output logic             peak_valid_o
);
  typedef struct packed {
    logic       bg_seen;
    logic       valid;
    logic [7:0] peak;
  } track_s;

  track_s q;
  track_s d;

  always_comb begin
    d = q;
    d.bg_seen = bg_active_i;
    // restart on a new background operation
    if (bg_active_i && !q.bg_seen) begin
      d.valid = 1'b0;
    end
    if (bg_active_i && strength_valid_i) begin
      // signed dBm reading
      if (!d.valid || ($signed(strength_i) > $signed(d.peak))) begin
        d.peak  = strength_i;
        d.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign peak_o       = q.peak;
  assign peak_valid_o = q.valid;
endmodule : strength_tracker

// [hdl/radio_command_decoder.sv]
// radio command decoder: axi4-lite register file, command dispatch and query answers
// assumes radio status inputs are synchronous to CLK_I; one command in flight at a time
//
// Contract
// - foreground stop ends the foreground operation gracefully; background keeps running.
// - foreground stop always reports done; no action without a foreground operation.
// - status for stop may be written before the foreground operation finishes.
// - foreground stop has no parameters and is accepted as identifier alone.
// - query returns present strength and peak since background operation start.
// - query returns combined, energy, correlator and syncword clear states.
// - without a valid strength reading both strength fields hold the marker.
// - query reports wrong context without background receive, else done.
// - low-energy operation identifiers decode as ten consecutive values.
// - one low-energy immediate command replaces the advertiser payload.
// - structure fields little-endian, aligned, bit zero least significant.
// - write-only fields never modified; read-write fields may be updated.
// - channel byte selects protocol channel, custom frequency, or keeps frequency.
// - whitener seed from bits 0-6 when overridden or custom; zero disables.
// - override clear gives default whitening; set uses supplied seed.
// - parameter and result pointers fetched; null result pointer stores nothing.
// - operation structure starts with 14-byte common header.
// - slave list holds queues, config, sequence state and zero-unlimited limits.
// - slave list holds four-byte access word then three-byte checksum seed.
// - slave list holds timeout trigger/time, reserved bytes, close trigger/time.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module radio_command_decoder
  import radio_cmd_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CE_I,
  // axi4-lite slave
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // radio core status
  input  wire logic        FG_ACTIVE_I,
  input  wire logic        BG_RX_ACTIVE_I,
  input  wire logic        BG_RX_SUSPENDED_I,
  input  wire logic [7:0]  STRENGTH_I,
  input  wire logic        STRENGTH_VALID_I,
  input  wire logic        COMBINED_CLEAR_I,
  input  wire logic        ENERGY_CLEAR_I,
  input  wire logic        CORRELATOR_CLEAR_I,
  input  wire logic        SYNCWORD_CLEAR_I,
  input  wire logic        SEQ_STATE_WE_I,
  input  wire logic [7:0]  SEQ_STATE_I,
  // radio core control
  output logic             FG_STOP_O,
  output logic             OP_START_O,
  output logic [3:0]       OP_INDEX_O,
  output logic             PAYLOAD_UPDATE_O,
  output logic             FREQ_KEEP_O,
  output logic             FREQ_CUSTOM_O,
  output logic [11:0]      FREQ_MHZ_O,
  output logic [5:0]       PROTO_CHANNEL_O,
  output logic             WHITEN_EN_O,
  output logic             WHITEN_DEFAULT_O,
  output logic [6:0]       WHITEN_SEED_O,
  output logic             STORE_RESULTS_O,
  output logic             NACK_LIMITED_O,
  output logic             PKT_LIMITED_O
);
  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] cmd_word;
    logic [7:0]  status;
    logic [31:0] query_result;
    logic [15:0] chan_whiten;
    logic [31:0] param_ptr;
    logic [31:0] result_ptr;
    logic [31:0] payload_desc;
    logic [31:0] new_data_ptr;
    logic [31:0] target_ptr;
    logic [31:0] rx_queue;
    logic [31:0] tx_queue;
    logic [31:0] queue_cfg;
    logic [31:0] access_word;
    logic [31:0] seed_trig;
    logic [31:0] timeout_time;
    logic [7:0]  close_trig;
    logic [31:0] close_time;
    logic        fg_stop;
    logic        op_start;
    logic [3:0]  op_index;
    logic        payload_upd;
    logic        freq_keep;
    logic        freq_custom;
    logic [11:0] freq_mhz;
    logic [5:0]  proto_chan;
    logic        whiten_en;
    logic        whiten_default;
    logic [6:0]  whiten_seed;
    logic        store_results;
    logic        nack_lim;
    logic        pkt_lim;
  } state_s;

  state_s q;
  state_s d;

  logic        ch_legal;
  logic        ch_keep;
  logic        ch_custom;
  logic [11:0] ch_mhz;
  logic        ch_wh_en;
  logic        ch_wh_def;
  logic [6:0]  ch_wh_seed;
  logic [7:0]  peak;
  logic        peak_valid;

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  channel_byte_decode u_chan (
    .channel_i        (q.chan_whiten[7:0]),
    .whitening_i      (q.chan_whiten[15:8]),
    .legal_o          (ch_legal),
    .keep_freq_o      (ch_keep),
    .custom_o         (ch_custom),
    .freq_mhz_o       (ch_mhz),
    .whiten_en_o      (ch_wh_en),
    .whiten_default_o (ch_wh_def),
    .whiten_seed_o    (ch_wh_seed)
  );

  strength_tracker u_peak (
    .clk_i            (CLK_I),
    .srst_i           (SRST_I),
    .ce_i             (CE_I),
    .bg_active_i      (BG_RX_ACTIVE_I),
    .strength_i       (STRENGTH_I),
    .strength_valid_i (STRENGTH_VALID_I),
    .peak_o           (peak),
    .peak_valid_o     (peak_valid)
  );

  always_comb begin
    logic [15:0] cmd_id;
    logic [31:0] wv;
    logic        mapped;
    logic [15:0] op_off;
    cmd_id = 16'h0000;
    wv     = 32'h0000_0000;
    mapped = 1'b0;
    op_off = 16'h0000;
    d = q;
    d.fg_stop     = 1'b0;
    d.op_start    = 1'b0;
    d.payload_upd = 1'b0;

    // write channel: address and data taken in either order
    if (q.bvalid && BREADY_I) begin
      d.bvalid = 1'b0;
    end
    if (AWVALID_I && q.aw_rdy) begin
      d.aw_have = 1'b1;
      d.aw_addr = AWADDR_I;
    end
    if (WVALID_I && q.w_rdy) begin
      d.w_have = 1'b1;
      d.w_data = WDATA_I;
      d.w_strb = WSTRB_I;
    end
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      mapped    = 1'b1;
      case ({d.aw_addr[7:2], 2'b00})
        ADDR_CMD: begin
          wv       = lane_merge(q.cmd_word, d.w_data, d.w_strb);
          d.cmd_word = wv;
          cmd_id   = wv[CMD_ID_LSB +: 16];
          op_off   = cmd_id - ID_LE_OP_FIRST;
          if (cmd_id == ID_FG_STOP) begin
            // identifier alone is enough; low half is not looked at
            d.fg_stop = FG_ACTIVE_I;
            d.status  = STA_DONE;
          end else if (cmd_id == ID_CLEAR_QUERY) begin
            if (BG_RX_ACTIVE_I || BG_RX_SUSPENDED_I) begin
              d.query_result = 32'h0000_0000;
              d.query_result[7:0] = STRENGTH_VALID_I ? STRENGTH_I : STRENGTH_INVALID;
              d.query_result[RES_PEAK_LSB +: 8] = peak_valid ? peak : STRENGTH_INVALID;
              d.query_result[RES_COMBINED]   = COMBINED_CLEAR_I;
              d.query_result[RES_ENERGY]     = ENERGY_CLEAR_I;
              d.query_result[RES_CORRELATOR] = CORRELATOR_CLEAR_I;
              d.query_result[RES_SYNCWORD]   = SYNCWORD_CLEAR_I;
              d.status = STA_DONE;
            end else begin
              // stale answer left untouched when the context is wrong
              d.status = STA_WRONG_CONTEXT;
            end
          end else if (cmd_id == ID_PAYLOAD_UPDATE) begin
            if (q.payload_desc[23:16] == KIND_ADVERT_DATA || q.payload_desc[23:16] == KIND_SCAN_RESP) begin
              d.payload_upd = 1'b1;
              d.status      = STA_DONE;
            end else begin
              d.status = STA_PARAM_ERROR;
            end
          end else if (cmd_id >= ID_LE_OP_FIRST && cmd_id <= ID_LE_OP_LAST) begin
            if (ch_legal) begin
              d.op_start       = 1'b1;
              d.op_index       = op_off[3:0];
              d.freq_keep      = ch_keep;
              d.freq_custom    = ch_custom;
              d.freq_mhz       = ch_mhz;
              d.proto_chan     = q.chan_whiten[5:0];
              d.whiten_en      = ch_wh_en;
              d.whiten_default = ch_wh_def;
              d.whiten_seed    = ch_wh_seed;
              d.store_results  = (q.result_ptr != 32'h0000_0000);
              d.status         = STA_DONE;
            end else begin
              d.status = STA_PARAM_ERROR;
            end
          end else begin
            d.status = STA_UNKNOWN_CMD;
          end
        end
        ADDR_CHAN_WHITEN: begin
          wv            = lane_merge({16'h0000, q.chan_whiten}, d.w_data, d.w_strb);
          d.chan_whiten = wv[15:0];
        end
        ADDR_PARAM_PTR:    d.param_ptr    = lane_merge(q.param_ptr, d.w_data, d.w_strb);
        ADDR_RESULT_PTR:   d.result_ptr   = lane_merge(q.result_ptr, d.w_data, d.w_strb);
        ADDR_PAYLOAD_DESC: d.payload_desc = lane_merge(q.payload_desc, d.w_data, d.w_strb);
        ADDR_NEW_DATA_PTR: d.new_data_ptr = lane_merge(q.new_data_ptr, d.w_data, d.w_strb);
        ADDR_TARGET_PTR:   d.target_ptr   = lane_merge(q.target_ptr, d.w_data, d.w_strb);
        ADDR_RX_QUEUE:     d.rx_queue     = lane_merge(q.rx_queue, d.w_data, d.w_strb);
        ADDR_TX_QUEUE:     d.tx_queue     = lane_merge(q.tx_queue, d.w_data, d.w_strb);
        ADDR_QUEUE_CFG:    d.queue_cfg    = lane_merge(q.queue_cfg, d.w_data, d.w_strb);
        ADDR_ACCESS_WORD:  d.access_word  = lane_merge(q.access_word, d.w_data, d.w_strb);
        ADDR_SEED_TRIG:    d.seed_trig    = lane_merge(q.seed_trig, d.w_data, d.w_strb);
        ADDR_TIMEOUT_TIME: d.timeout_time = lane_merge(q.timeout_time, d.w_data, d.w_strb);
        ADDR_CLOSE_TRIG: begin
          // bytes 0..2 are reserved; only the trigger byte is kept
          wv           = lane_merge({q.close_trig, 24'h00_0000}, d.w_data, d.w_strb);
          d.close_trig = wv[31:24];
        end
        ADDR_CLOSE_TIME:   d.close_time   = lane_merge(q.close_time, d.w_data, d.w_strb);
        ADDR_STATUS, ADDR_QUERY_RESULT, ADDR_RADIO_STATE: mapped = 1'b1;
        default:           mapped = 1'b0;
      endcase
      d.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end
    // sequence state is the only field the radio side may change
    if (SEQ_STATE_WE_I) begin
      d.queue_cfg[CFG_SEQ_LSB +: 8] = SEQ_STATE_I;
    end
    // zero means no limit
    d.nack_lim = (d.queue_cfg[CFG_NACK_LSB +: 8] != 8'h00);
    d.pkt_lim  = (d.queue_cfg[CFG_PKT_LSB +: 8] != 8'h00);
    d.aw_rdy = !d.aw_have && !d.bvalid;
    d.w_rdy  = !d.w_have && !d.bvalid;

    // read channel
    if (q.rvalid && RREADY_I) begin
      d.rvalid = 1'b0;
    end
    if (ARVALID_I && q.ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case ({ARADDR_I[7:2], 2'b00})
        ADDR_CMD:          d.rdata = q.cmd_word;
        ADDR_STATUS:       d.rdata = {24'h00_0000, q.status};
        ADDR_QUERY_RESULT: d.rdata = q.query_result;
        ADDR_CHAN_WHITEN:  d.rdata = {16'h0000, q.chan_whiten};
        ADDR_PARAM_PTR:    d.rdata = q.param_ptr;
        ADDR_RESULT_PTR:   d.rdata = q.result_ptr;
        ADDR_PAYLOAD_DESC: d.rdata = q.payload_desc;
        ADDR_NEW_DATA_PTR: d.rdata = q.new_data_ptr;
        ADDR_TARGET_PTR:   d.rdata = q.target_ptr;
        ADDR_RX_QUEUE:     d.rdata = q.rx_queue;
        ADDR_TX_QUEUE:     d.rdata = q.tx_queue;
        ADDR_QUEUE_CFG:    d.rdata = q.queue_cfg;
        ADDR_ACCESS_WORD:  d.rdata = q.access_word;
        ADDR_SEED_TRIG:    d.rdata = q.seed_trig;
        ADDR_TIMEOUT_TIME: d.rdata = q.timeout_time;
        ADDR_CLOSE_TRIG:   d.rdata = {q.close_trig, 24'h00_0000};
        ADDR_CLOSE_TIME:   d.rdata = q.close_time;
        ADDR_RADIO_STATE:  d.rdata = {16'h0000, peak, 4'h0, peak_valid, BG_RX_SUSPENDED_I,
                                      BG_RX_ACTIVE_I, FG_ACTIVE_I};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    d.ar_rdy = !d.rvalid;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      q        <= '0;
      q.aw_rdy <= 1'b1;
      q.w_rdy  <= 1'b1;
      q.ar_rdy <= 1'b1;
      q.status <= STA_IDLE;
    end else if (CE_I) begin
      q <= d;
    end
  end

  assign AWREADY_O            = q.aw_rdy;
  assign WREADY_O             = q.w_rdy;
  assign BVALID_O             = q.bvalid;
  assign BRESP_O              = q.bresp;
  assign ARREADY_O            = q.ar_rdy;
  assign RVALID_O             = q.rvalid;
  assign RRESP_O              = q.rresp;
  assign RDATA_O              = q.rdata;
  assign FG_STOP_O            = q.fg_stop;
  assign OP_START_O           = q.op_start;
  assign OP_INDEX_O           = q.op_index;
  assign PAYLOAD_UPDATE_O     = q.payload_upd;
  assign FREQ_KEEP_O          = q.freq_keep;
  assign FREQ_CUSTOM_O        = q.freq_custom;
  assign FREQ_MHZ_O           = q.freq_mhz;
  assign PROTO_CHANNEL_O      = q.proto_chan;
  assign WHITEN_EN_O          = q.whiten_en;
  assign WHITEN_DEFAULT_O     = q.whiten_default;
  assign WHITEN_SEED_O        = q.whiten_seed;
  assign STORE_RESULTS_O      = q.store_results;
  assign NACK_LIMITED_O       = q.nack_lim;
  assign PKT_LIMITED_O        = q.pkt_lim;
endmodule : radio_command_decoder

// [verif/radio_cmd_assertions.sv]
// checker for the radio command decoder ports
// bound to every decoder instance; sees top-level ports only
`timescale 1ns/100ps
module radio_cmd_assertions
  import radio_cmd_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        FG_ACTIVE_I,
  input wire logic        BREADY_I,
  input wire logic        RREADY_I,
  input wire logic        BVALID_O,
  input wire logic [1:0]  BRESP_O,
  input wire logic        RVALID_O,
  input wire logic [31:0] RDATA_O,
  input wire logic        FG_STOP_O,
  input wire logic        OP_START_O,
  input wire logic [3:0]  OP_INDEX_O,
  input wire logic        PAYLOAD_UPDATE_O,
  input wire logic        FREQ_CUSTOM_O,
  input wire logic [11:0] FREQ_MHZ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_stop_needs_fg: assert property (FG_STOP_O |-> $past(FG_ACTIVE_I)) else $error("stop without fg");
  a_stop_one_cycle: assert property (FG_STOP_O |=> !FG_STOP_O) else $error("stop not a pulse");
  a_stop_early_done: assert property (FG_STOP_O |-> BVALID_O && BRESP_O == RESP_OKAY) else $error("stop resp");
  a_bresp_stands: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O)) else $error("bresp");
  a_rdata_stands: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("rdata");
  a_op_index_range: assert property (OP_START_O |-> OP_INDEX_O <= 4'd9 && BVALID_O) else $error("op index");
  a_custom_freq: assert property (FREQ_CUSTOM_O |-> FREQ_MHZ_O inside {[12'd2360:12'd2507]})
    else $error("custom freq");
  a_payload_pulse: assert property (PAYLOAD_UPDATE_O |-> BVALID_O ##1 !PAYLOAD_UPDATE_O) else $error("payload");
endmodule : radio_cmd_assertions
bind radio_command_decoder radio_cmd_assertions u_chk (.*);

// [verif/radio_core_model.sv]
// partner: radio core foreground operation
// assumes start and stop pulses on the core clock
`timescale 1ns/100ps
module radio_core_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      fg_active_o
);
  logic [1:0] drain_q;
  // graceful stop winds down later than the status answer
  always_ff @(posedge clk_i) begin
    if (srst_i || drain_q == 2'd1) begin
      fg_active_o <= 1'b0;
      drain_q     <= 2'd0;
    end else if (stop_i && fg_active_o) begin
      drain_q <= 2'd3;
    end else if (start_i) begin
      fg_active_o <= 1'b1;
    end else if (drain_q != 2'd0) begin
      drain_q <= drain_q - 2'd1;
    end
  end
endmodule : radio_core_model

// [verif/tb_radio_command_decoder.sv]
// bench: axi4-lite master plus radio status stimulus
// assumes the core model for foreground activity
`timescale 1ns/100ps
module tb_radio_command_decoder
  import radio_cmd_pkg::*;
;
  logic        CLK_I = 0, SRST_I = 1, CE_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, fg_go = 0;
  logic        RREADY_I = 0, BG_RX_ACTIVE_I = 0, BG_RX_SUSPENDED_I = 0, STRENGTH_VALID_I = 0, SEQ_STATE_WE_I = 0;
  logic        COMBINED_CLEAR_I = 0, ENERGY_CLEAR_I = 0, CORRELATOR_CLEAR_I = 0, SYNCWORD_CLEAR_I = 0, stop_seen;
  logic [7:0]  AWADDR_I = 0, ARADDR_I = 0, STRENGTH_I = 0, SEQ_STATE_I = 0;
  logic [31:0] WDATA_I = 0, rd_seen, RDATA_O;
  logic [3:0]  WSTRB_I = 4'hF, OP_INDEX_O;
  logic [1:0]  BRESP_O, RRESP_O, bresp_seen, rresp_seen;
  logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, FG_ACTIVE_I, FG_STOP_O, OP_START_O;
  logic        FREQ_KEEP_O, FREQ_CUSTOM_O, WHITEN_EN_O, WHITEN_DEFAULT_O, STORE_RESULTS_O, PAYLOAD_UPDATE_O;
  logic        NACK_LIMITED_O, PKT_LIMITED_O;
  logic [11:0] FREQ_MHZ_O;
  logic [5:0]  PROTO_CHANNEL_O;
  logic [6:0]  WHITEN_SEED_O;
  int          err_count = 0, n_compared = 0;
  always #20 CLK_I = ~CLK_I;
  radio_command_decoder dut (.*);
  radio_core_model core (.clk_i(CLK_I), .srst_i(SRST_I), .start_i(fg_go), .stop_i(FG_STOP_O),
                         .fg_active_o(FG_ACTIVE_I));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ready offered with the request; one idle edge after the answer keeps calls apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge CLK_I);
      if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
      if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
      if (BVALID_O && BREADY_I) begin
        BREADY_I <= 1'b0;
        stop_seen = FG_STOP_O;
        bresp_seen = BRESP_O;
        @(posedge CLK_I);
        return;
      end
    end
    err_count++;
    end_of_test();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge CLK_I);
      if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
      if (RVALID_O && RREADY_I) begin
        RREADY_I <= 1'b0;
        rd_seen = RDATA_O;
        rresp_seen = RRESP_O;
        @(posedge CLK_I);
        return;
      end
    end
    err_count++;
    end_of_test();
  endtask : rd
  task automatic cmd(input logic [15:0] id, input logic [7:0] sta);
    wr(ADDR_CMD, {id, 16'h0000});
    rd(ADDR_STATUS);
    chk("status", {24'h00_0000, sta}, rd_seen);
  endtask : cmd
  task automatic t_bus();
    rd(ADDR_STATUS);
    chk("status reset", 32'h0000_0000, rd_seen);
    rd(8'hFC);
    chk("unmapped rresp", 32'h0000_0002, {30'h0, rresp_seen});
    wr(8'hFC, 32'h0000_0001);
    chk("unmapped bresp", 32'h0000_0002, {30'h0, bresp_seen});
    wr(ADDR_PARAM_PTR, 32'h2000_1234);
    rd(ADDR_PARAM_PTR);
    chk("param ptr", 32'h2000_1234, rd_seen);
    wr(ADDR_QUEUE_CFG, 32'h0100_0000);
    chk("limits", 32'h0000_0002, {30'h0, PKT_LIMITED_O, NACK_LIMITED_O});
    SEQ_STATE_I <= 8'h5A;
    SEQ_STATE_WE_I <= 1'b1;
    @(posedge CLK_I);
    SEQ_STATE_WE_I <= 1'b0;
    rd(ADDR_QUEUE_CFG);
    chk("seq state", 32'h0100_5A00, rd_seen);
  endtask : t_bus
  task automatic t_stop();
    cmd(ID_FG_STOP, STA_DONE);
    chk("idle stop", 32'h0000_0000, {31'h0, stop_seen});
    fg_go <= 1'b1;
    @(posedge CLK_I);
    fg_go <= 1'b0;
    cmd(ID_FG_STOP, STA_DONE);
    chk("stop pulse", 32'h0000_0001, {31'h0, stop_seen});
  endtask : t_stop
  task automatic t_query();
    cmd(ID_CLEAR_QUERY, STA_WRONG_CONTEXT);
    BG_RX_SUSPENDED_I <= 1'b1;
    cmd(ID_CLEAR_QUERY, STA_DONE);
    BG_RX_SUSPENDED_I <= 1'b0;
    BG_RX_ACTIVE_I <= 1'b1;
    COMBINED_CLEAR_I <= 1'b1;
    CORRELATOR_CLEAR_I <= 1'b1;
    cmd(ID_CLEAR_QUERY, STA_DONE);
    rd(ADDR_QUERY_RESULT);
    chk("no reading", 32'h0005_8080, rd_seen & 32'h000F_FFFF);
    STRENGTH_I <= 8'h20;
    STRENGTH_VALID_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    STRENGTH_I <= 8'hF0;
    cmd(ID_CLEAR_QUERY, STA_DONE);
    rd(ADDR_QUERY_RESULT);
    chk("query result", 32'h0005_20F0, rd_seen & 32'h000F_FFFF);
  endtask : t_query
  task automatic t_ops();
    wr(ADDR_CHAN_WHITEN, 32'h0000_000A);
    for (int i = 0; i < 10; i++) begin
      cmd(ID_LE_OP_FIRST + 16'(i), STA_DONE);
      chk("op index", 32'h0000_0030 + 32'(i), {26'h0, WHITEN_EN_O, WHITEN_DEFAULT_O, OP_INDEX_O});
    end
    cmd(ID_LE_OP_LAST + 16'h0001, STA_UNKNOWN_CMD);
    wr(ADDR_CHAN_WHITEN, 32'h0000_0064);
    cmd(ID_LE_OP_FIRST, STA_DONE);
    chk("custom mhz", 32'h0000_4960, {17'h0, FREQ_CUSTOM_O, WHITEN_EN_O, WHITEN_DEFAULT_O, FREQ_MHZ_O});
    wr(ADDR_CHAN_WHITEN, 32'h0000_00FF);
    cmd(ID_LE_OP_FIRST, STA_DONE);
    chk("keep freq", 32'h0000_0001, {30'h0, STORE_RESULTS_O, FREQ_KEEP_O});
    wr(ADDR_CHAN_WHITEN, 32'h0000_0032);
    cmd(ID_LE_OP_FIRST, STA_PARAM_ERROR);
  endtask : t_ops
  task automatic t_payload();
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_PAYLOAD_DESC, {8'h04, 8'(k), ID_PAYLOAD_UPDATE});
      cmd(ID_PAYLOAD_UPDATE, (k < 2) ? STA_DONE : STA_PARAM_ERROR);
    end
  endtask : t_payload
  initial begin
    repeat (3) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    t_bus();
    t_stop();
    t_query();
    t_ops();
    t_payload();
    end_of_test();
  end
endmodule : tb_radio_command_decoder
